/* verilog/vin_ctrl_pkg.sv */
// Package of constants, types and register layout for the video input port control block
package vin_ctrl_pkg;
  // Register byte addresses
  localparam logic [7:0] HOST_MODE_ADDR = 8'h00;
  // Input control sits at word index 2; the bus sees it at four times that
  localparam int INPUT_CTRL_INDEX = 2;
  localparam logic [7:0] INPUT_CTRL_ADDR = 8'(4 * INPUT_CTRL_INDEX);
  localparam logic [7:0] SOFT_RESET_ADDR = 8'h0C;
  localparam logic [7:0] STATUS_ADDR = 8'h10;
  // Host mode control field positions
  localparam int FMT_BIT = 4;
  localparam int BYPASS_BIT = 7;
  localparam int RSVD_BIT = 8;
  localparam int STANDBY_BIT = 9;
  localparam int PORTSEL_BIT = 10;
  localparam logic [10:0] HOST_MODE_RESET = 11'h000;
  // Input control field positions
  localparam int RUN_BIT = 0;
  localparam int WIDE_BIT = 1;
  localparam int OFFS_BIT = 2;
  localparam int INTLC_BIT = 3;
  localparam int CREF_INV_BIT = 4;
  localparam int HS_INV_BIT = 5;
  localparam int VS_INV_BIT = 6;
  localparam int ODD_INV_BIT = 7;
  localparam logic [7:0] INPUT_CTRL_RESET = 8'h00;
  // Bypass pipeline depth in cycles
  localparam int BYPASS_DELAY = 2;
  // Window state machine
  typedef enum logic [1:0] {WIN_IDLE, WIN_ARMED, WIN_ACTIVE} win_state_t;
  // Control lines of one video port
  typedef struct packed {
    logic cref;
    logic hs;
    logic vs;
  } port_ctl_t;
endpackage

/* verilog/video_input_port_control.sv */
// Video input port control: registers over AHB-Lite, input sampling, window arm and bypass path
`timescale 1ns/100ps
module video_input_port_control #(
  parameter int PIX_W = 24
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // First video port
  input wire logic FIRST_PORT_PIXEL_CLOCK,
  input wire logic [2*PIX_W-1:0] FIRST_PORT_DATA,
  input wire vin_ctrl_pkg::port_ctl_t FIRST_PORT_CTL,
  // Second video port
  input wire logic [PIX_W-1:0] SECOND_PORT_DATA,
  input wire vin_ctrl_pkg::port_ctl_t SECOND_PORT_CTL,
  input wire logic ODD_FIELD_INPUT,
  // Scaler side
  output logic SCALER_REQUEST_OUT,
  output logic SCALER_BLANK_OUT,
  output logic PIXEL_VALID,
  output logic [2*PIX_W-1:0] PIXEL_DATA,
  output logic PIXEL_PAIR,
  output logic FIELD_ODD,
  output logic LINE_START,
  // Bypass display output
  output logic [2*PIX_W-1:0] DISPLAY_DATA,
  output vin_ctrl_pkg::port_ctl_t DISPLAY_CTL,
  output logic DISPLAY_CLOCK
);

  // Register file and bus phase state
  logic [10:0] host_mode_reg;
  logic [7:0] input_ctrl_reg;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic soft_reset_reg;

  // Address phase capture; slave answers with zero wait states
  wire addr_ok = HSEL && HREADY && HTRANS[1];
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= addr_ok && HWRITE;
      wr_addr_reg <= HADDR[7:0];
    end
  end
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  // Soft reset strobe, one cycle, from a write of bit 0 to the soft reset address
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      soft_reset_reg <= 1'b0;
    end else begin
      soft_reset_reg <= wr_pend_reg && wr_addr_reg == vin_ctrl_pkg::SOFT_RESET_ADDR && HWDATA[0];
    end
  end

  // Host mode control: a soft reset leaves it alone, so mode bits survive it
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      host_mode_reg <= vin_ctrl_pkg::HOST_MODE_RESET;
    end else if (wr_pend_reg && wr_addr_reg == vin_ctrl_pkg::HOST_MODE_ADDR) begin
      host_mode_reg <= HWDATA[10:0];
    end
  end

  // Input control is cleared by a soft reset, which also stops the window
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      input_ctrl_reg <= vin_ctrl_pkg::INPUT_CTRL_RESET;
    end else if (soft_reset_reg) begin
      input_ctrl_reg <= vin_ctrl_pkg::INPUT_CTRL_RESET;
    end else if (wr_pend_reg && wr_addr_reg == vin_ctrl_pkg::INPUT_CTRL_ADDR) begin
      input_ctrl_reg <= HWDATA[7:0];
    end
  end

  // Decoded control bits
  wire bypass_en = host_mode_reg[vin_ctrl_pkg::BYPASS_BIT];
  wire standby = host_mode_reg[vin_ctrl_pkg::STANDBY_BIT];
  wire rgb_mode = host_mode_reg[vin_ctrl_pkg::FMT_BIT];
  wire port_sel = host_mode_reg[vin_ctrl_pkg::PORTSEL_BIT];
  wire run_en = input_ctrl_reg[vin_ctrl_pkg::RUN_BIT];
  wire wide_en = input_ctrl_reg[vin_ctrl_pkg::WIDE_BIT];
  wire offs_en = input_ctrl_reg[vin_ctrl_pkg::OFFS_BIT];
  wire intlc_en = input_ctrl_reg[vin_ctrl_pkg::INTLC_BIT];

  // Two-flop synchronisers for every pin that is sampled, data included
  // Data shares the flops of the pixel clock, so a pixel stays aligned with its edge
  localparam int SYNC_W = 2*PIX_W + PIX_W + 3 + 3 + 2;
  logic [SYNC_W-1:0] pin_s1_reg;
  logic [SYNC_W-1:0] pin_s2_reg;
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
    end else begin
      pin_s1_reg <= {FIRST_PORT_DATA, SECOND_PORT_DATA, FIRST_PORT_CTL, SECOND_PORT_CTL,
                     ODD_FIELD_INPUT, FIRST_PORT_PIXEL_CLOCK};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // Unpack the synchronised pins
  wire [2*PIX_W-1:0] a_data = pin_s2_reg[SYNC_W-1 -: 2*PIX_W];
  wire [PIX_W-1:0] b_data = pin_s2_reg[PIX_W+7:8];
  vin_ctrl_pkg::port_ctl_t a_ctl;
  vin_ctrl_pkg::port_ctl_t b_ctl;
  assign a_ctl = pin_s2_reg[7:5];
  assign b_ctl = pin_s2_reg[4:2];
  wire odd_pin = pin_s2_reg[1];
  wire pclk_s = pin_s2_reg[0];

  // Source select: second port for YUV, or for RGB of either width with port select set
  wire use_b = !rgb_mode || port_sel;
  vin_ctrl_pkg::port_ctl_t sel_ctl;
  assign sel_ctl = use_b ? b_ctl : a_ctl;

  // Polarity correction ahead of edge detection and qualification
  wire cref_c = sel_ctl.cref ^ input_ctrl_reg[vin_ctrl_pkg::CREF_INV_BIT];
  wire hs_c = sel_ctl.hs ^ input_ctrl_reg[vin_ctrl_pkg::HS_INV_BIT];
  wire vs_c = sel_ctl.vs ^ input_ctrl_reg[vin_ctrl_pkg::VS_INV_BIT];
  wire odd_c = odd_pin ^ input_ctrl_reg[vin_ctrl_pkg::ODD_INV_BIT];

  // Previous levels for edge detection of the corrected signals and the pixel clock
  logic hs_prev_reg;
  logic vs_prev_reg;
  logic pclk_prev_reg;
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      hs_prev_reg <= 1'b0;
      vs_prev_reg <= 1'b0;
      pclk_prev_reg <= 1'b0;
    end else begin
      hs_prev_reg <= hs_c;
      vs_prev_reg <= vs_c;
      pclk_prev_reg <= pclk_s;
    end
  end
  wire hs_edge = hs_c && !hs_prev_reg;
  wire vs_edge = vs_c && !vs_prev_reg;
  wire pclk_rise = pclk_s && !pclk_prev_reg;
  // A pixel is taken on a qualified rising pixel clock edge
  wire pix_take = pclk_rise && cref_c;

  // Window state: idle until run, armed until next vsync, then active
  vin_ctrl_pkg::win_state_t win_reg;
  vin_ctrl_pkg::win_state_t win_next;
  always_comb begin
    win_next = win_reg;
    case (win_reg)
      vin_ctrl_pkg::WIN_IDLE: begin
        if (run_en) begin
          win_next = vin_ctrl_pkg::WIN_ARMED;
        end
      end
      vin_ctrl_pkg::WIN_ARMED: begin
        if (vs_edge) begin
          win_next = vin_ctrl_pkg::WIN_ACTIVE;
        end
      end
      vin_ctrl_pkg::WIN_ACTIVE: begin
        win_next = vin_ctrl_pkg::WIN_ACTIVE;
      end
      default: begin
        win_next = vin_ctrl_pkg::WIN_IDLE;
      end
    endcase
    // Clearing run, or setting standby or bypass, holds the window in reset
    if (!run_en || standby || bypass_en) begin
      win_next = vin_ctrl_pkg::WIN_IDLE;
    end
  end
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      win_reg <= vin_ctrl_pkg::WIN_IDLE;
    end else begin
      win_reg <= win_next;
    end
  end
  wire active = win_reg == vin_ctrl_pkg::WIN_ACTIVE;

  // Offset double mode: the first half waits for its partner on the next edge
  logic half_reg;
  logic [PIX_W-1:0] first_half_reg;
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      half_reg <= 1'b0;
      first_half_reg <= '0;
    end else if (!active || !offs_en || hs_edge) begin
      half_reg <= 1'b0; // Line start realigns the pair
    end else if (pix_take) begin
      half_reg <= !half_reg;
      first_half_reg <= a_data[PIX_W-1:0];
    end
  end

  // Scaler data output, registered
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PIXEL_VALID <= 1'b0;
      PIXEL_DATA <= '0;
      PIXEL_PAIR <= 1'b0;
    end else begin
      PIXEL_VALID <= 1'b0;
      if (active && pix_take) begin
        if (use_b) begin
          PIXEL_VALID <= 1'b1;
          PIXEL_DATA <= {{PIX_W{1'b0}}, b_data};
          PIXEL_PAIR <= 1'b0;
        end else if (offs_en) begin
          PIXEL_VALID <= half_reg;
          PIXEL_DATA <= {a_data[PIX_W-1:0], first_half_reg};
          PIXEL_PAIR <= 1'b1;
        end else begin
          PIXEL_VALID <= 1'b1;
          PIXEL_DATA <= wide_en ? a_data : {{PIX_W{1'b0}}, a_data[PIX_W-1:0]};
          PIXEL_PAIR <= wide_en;
        end
      end
    end
  end

  // Field and line status: non-interlaced frames decode as odd fields
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      FIELD_ODD <= 1'b1;
      LINE_START <= 1'b0;
    end else begin
      // Standby pins the field flag so no output follows the pin while idle
      FIELD_ODD <= (intlc_en && !standby) ? odd_c : 1'b1;
      LINE_START <= active && hs_edge;
    end
  end

  // Request and blank: request high and blank low whenever the window is not open
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      SCALER_REQUEST_OUT <= 1'b1;
      SCALER_BLANK_OUT <= 1'b0;
    end else begin
      SCALER_REQUEST_OUT <= !(win_next == vin_ctrl_pkg::WIN_ACTIVE);
      SCALER_BLANK_OUT <= win_next == vin_ctrl_pkg::WIN_ACTIVE && cref_c;
    end
  end

  // Bypass path: two register stages from first port pins to display, zero in standby
  // Limitation: the pin synchronisers add their own two cycles ahead of these stages
  logic [2*PIX_W+3:0] byp_reg [vin_ctrl_pkg::BYPASS_DELAY];
  wire [2*PIX_W+3:0] byp_in = (bypass_en && !standby) ? {a_data, a_ctl, pclk_s} : '0;
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      byp_reg[0] <= '0;
      byp_reg[1] <= '0;
    end else begin
      byp_reg[0] <= byp_in;
      byp_reg[1] <= byp_reg[0];
    end
  end
  assign DISPLAY_DATA = byp_reg[1][2*PIX_W+3:4];
  assign DISPLAY_CTL = byp_reg[1][3:1];
  assign DISPLAY_CLOCK = byp_reg[1][0];

  // Read data, registered in the data phase
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      HRDATA <= 32'h00000000;
    end else if (addr_ok && !HWRITE) begin
      case (HADDR[7:0])
        vin_ctrl_pkg::HOST_MODE_ADDR: HRDATA <= {21'h0, host_mode_reg};
        vin_ctrl_pkg::INPUT_CTRL_ADDR: HRDATA <= {24'h000000, input_ctrl_reg};
        vin_ctrl_pkg::STATUS_ADDR: HRDATA <= {28'h0000000, FIELD_ODD, half_reg, win_reg};
        default: HRDATA <= 32'h00000000;
      endcase
    end
  end

  // Checks
  run_low_idle_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    !run_en |=> ##1 (SCALER_REQUEST_OUT && !SCALER_BLANK_OUT)) else $error("request or blank wrong while stopped");
  arm_waits_vsync_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (win_reg == vin_ctrl_pkg::WIN_ARMED && !vs_edge) |=> win_reg != vin_ctrl_pkg::WIN_ACTIVE) else $error("window opened without vsync");
  standby_static_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    standby [*3] |-> (DISPLAY_DATA == '0 && !PIXEL_VALID)) else $error("outputs move in standby");
  bypass_delay_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (bypass_en && !standby) [*3] |-> DISPLAY_DATA == $past(a_data, 2)) else $error("bypass delay wrong");
  mode_keep_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (soft_reset_reg && !wr_pend_reg) |=> $stable(host_mode_reg)) else $error("mode bits lost on soft reset");
  field_odd_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    !intlc_en |=> FIELD_ODD) else $error("non-interlaced field not odd");
  offset_pair_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (PIXEL_VALID && PIXEL_PAIR && offs_en && !use_b) |-> PIXEL_DATA[PIX_W-1:0] == $past(first_half_reg)) else $error("offset pair wrong");
  single_width_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (PIXEL_VALID && !PIXEL_PAIR) |-> PIXEL_DATA[2*PIX_W-1:PIX_W] == '0) else $error("single pixel upper half not zero");

  // Checks on the window and the scaler handshake
  request_window_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    active |-> !SCALER_REQUEST_OUT)
    else $error("request high while window open");
  blank_closed_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    !active |-> !SCALER_BLANK_OUT)
    else $error("blank high while window closed");
  no_pixel_idle_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    !active |=> !PIXEL_VALID)
    else $error("pixel sent while window closed");
  line_start_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    LINE_START |-> $past(active))
    else $error("line start outside window");

  // Checks on the data paths
  port_b_single_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (PIXEL_VALID && $past(use_b)) |-> !PIXEL_PAIR)
    else $error("second port pixel marked as pair");
  bypass_off_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (!bypass_en || standby) [*3] |-> (DISPLAY_DATA == '0 && !DISPLAY_CLOCK))
    else $error("display moves with bypass off");

  // Checks on standby
  standby_idle_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    standby |=> win_reg == vin_ctrl_pkg::WIN_IDLE)
    else $error("window running in standby");
  standby_field_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    standby |=> FIELD_ODD)
    else $error("field flag moves in standby");

  // Scenario covers
  win_open_c: cover property (@(posedge REF_CLK) disable iff (!RST_N) win_reg == vin_ctrl_pkg::WIN_ARMED ##1 active);
  standby_c: cover property (@(posedge REF_CLK) disable iff (!RST_N) standby ##1 standby);
  line_c: cover property (@(posedge REF_CLK) disable iff (!RST_N) LINE_START);
  pix_out_c: cover property (@(posedge REF_CLK) disable iff (!RST_N) PIXEL_VALID && PIXEL_PAIR);
  bypass_c: cover property (@(posedge REF_CLK) disable iff (!RST_N) bypass_en && DISPLAY_CLOCK);

endmodule // video_input_port_control

/* tb/video_source.sv */
// Behavioural video source driving both pixel ports from its own pixel clock
`timescale 1ns/100ps
module video_source (
  // Pixel clock, still between transfers
  output logic pclk,
  // First port
  output logic [47:0] first_data,
  output vin_ctrl_pkg::port_ctl_t first_ctl,
  // Second port and field flag
  output logic [23:0] second_data,
  output vin_ctrl_pkg::port_ctl_t second_ctl,
  output logic odd
);
  // Idle levels before the first frame
  initial begin
    pclk = 1'h0;
    first_data = 48'h0;
    first_ctl = '0;
    second_data = 24'h0;
    second_ctl = '0;
    odd = 1'h0;
  end

  // Syncs go to both ports, so whichever is selected sees them
  task automatic sync(input logic hs, input logic vs);
    first_ctl.hs = hs;
    first_ctl.vs = vs;
    second_ctl.hs = hs;
    second_ctl.vs = vs;
    #200;
  endtask

  // One pixel over one 125 ns period; data released to its inverse after
  task automatic pixel(input logic sel, input logic cref, input logic [47:0] d);
    if (sel) begin
      second_data = d[23:0];
      second_ctl.cref = cref;
    end else begin
      first_data = d;
      first_ctl.cref = cref;
    end
    #31.25 pclk = 1'h1;
    #62.5 pclk = 1'h0;
    #31.25;
    // Stale bus must not look like a valid pixel
    first_data = ~first_data;
    second_data = ~second_data;
  endtask

  // Field flag level, held until changed
  task automatic field(input logic o);
    odd = o;
  endtask

  // Steady data under a few clocks, as a bypassed stream would see
  task automatic stream(input logic [47:0] d);
    first_data = d;
    repeat (4) #62.5 pclk = ~pclk;
  endtask
endmodule // video_source

/* tb/video_input_port_control_test.sv */
// Self-checking bench for the video input port control block
`timescale 1ns/100ps
`define CHK(got, exp) begin \
  n_compared++; \
  if ((got) !== (exp)) begin \
    error_cnt++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end
module video_input_port_control_test;
  localparam logic [7:0] HM = vin_ctrl_pkg::HOST_MODE_ADDR;
  localparam logic [7:0] IC = vin_ctrl_pkg::INPUT_CTRL_ADDR;
  localparam logic [7:0] SR = vin_ctrl_pkg::SOFT_RESET_ADDR;
  logic ref_clk, rst_n, hsel, hwrite, hreadyout, hresp, pclk, odd;
  logic req, blank, pvalid, ppair, fodd, lstart, dclk, last_pair;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [47:0] first_data, pdata, ddata, last_data;
  logic [23:0] second_data;
  vin_ctrl_pkg::port_ctl_t first_ctl, second_ctl, dctl;
  int error_cnt = 0;
  int n_compared = 0;
  int vcnt = 0;
  int lcnt = 0;
  int cyc = 0;

  video_input_port_control DUT (.REF_CLK(ref_clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .FIRST_PORT_PIXEL_CLOCK(pclk),
    .FIRST_PORT_DATA(first_data), .FIRST_PORT_CTL(first_ctl), .SECOND_PORT_DATA(second_data),
    .SECOND_PORT_CTL(second_ctl), .ODD_FIELD_INPUT(odd), .SCALER_REQUEST_OUT(req),
    .SCALER_BLANK_OUT(blank), .PIXEL_VALID(pvalid), .PIXEL_DATA(pdata), .PIXEL_PAIR(ppair),
    .FIELD_ODD(fodd), .LINE_START(lstart), .DISPLAY_DATA(ddata), .DISPLAY_CTL(dctl),
    .DISPLAY_CLOCK(dclk));
  video_source src (.pclk(pclk), .first_data(first_data), .first_ctl(first_ctl),
    .second_data(second_data), .second_ctl(second_ctl), .odd(odd));

  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  // Tally pulses as the scaler sees them; cut a hang short
  always @(posedge ref_clk) begin
    cyc++;
    if (pvalid === 1'h1) begin
      vcnt++;
      last_data = pdata;
      last_pair = ppair;
    end
    if (lstart === 1'h1) lcnt++;
    if (cyc > 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // One AHB-Lite single word transfer; read data taken at the data phase edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge ref_clk);
    while (hreadyout !== 1'h1) @(posedge ref_clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge ref_clk);
    while (hreadyout !== 1'h1) @(posedge ref_clk);
    rd = hrdata;
    `CHK(hresp, 1'h0)
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    `CHK(rd, e)
  endtask

  // Send one pixel and expect n pulses within a bounded wait
  task automatic pix(input logic sel, input logic cref, input logic [47:0] d, input int n,
    input logic [47:0] e);
    int old;
    int k;
    old = vcnt;
    k = 0;
    src.pixel(sel, cref, d);
    while (vcnt - old < n && k < 20) begin
      @(posedge ref_clk);
      k++;
    end
    if (n == 0) repeat (20) @(posedge ref_clk);
    `CHK(vcnt - old, n)
    if (n > 0) `CHK(last_data, e)
  endtask

  // Vsync pulse with hsync held high
  task automatic frame();
    src.sync(1'h1, 1'h1);
    src.sync(1'h1, 1'h0);
  endtask

  task automatic report_and_stop();
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Main sequence; bit 8 of host mode is always written as zero
  initial begin
    int n;
    ref_clk = 1'h0;
    rst_n = 1'h0;
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'h1;
    `CHK(req, 1'h1)
    `CHK(blank, 1'h0)
    rdc(HM, 32'h0);
    rdc(IC, 32'h0);
    rdc(8'h40, 32'h0);
    wr(HM, 32'h10);
    wr(IC, 32'h1);
    pix(1'h0, 1'h1, 48'hAA_123456, 0, 48'h0);
    `CHK(req, 1'h1)
    frame();
    `CHK(req, 1'h0)
    `CHK(blank, 1'h1)
    pix(1'h0, 1'h1, 48'hAA_123456, 1, 48'h123456);
    `CHK(last_pair, 1'h0)
    wr(IC, 32'h3);
    pix(1'h0, 1'h1, 48'hABCDEF_654321, 1, 48'hABCDEF_654321);
    `CHK(last_pair, 1'h1)
    wr(IC, 32'h5);
    pix(1'h0, 1'h1, 48'h111111, 0, 48'h0);
    pix(1'h0, 1'h1, 48'h222222, 1, 48'h222222_111111);
    wr(IC, 32'h11);
    pix(1'h0, 1'h1, 48'h333333, 0, 48'h0);
    pix(1'h0, 1'h0, 48'h333333, 1, 48'h333333);
    for (int i = 0; i < 2; i++) begin
      src.sync(i[0], 1'h0);
      wr(IC, 32'h1 | (i << 5));
      n = lcnt;
      src.sync(!i[0], 1'h0);
      `CHK(lcnt - n, 1)
      src.sync(i[0], 1'h0);
      `CHK(lcnt - n, 1)
    end
    wr(IC, 32'h0);
    src.sync(1'h1, 1'h1);
    wr(IC, 32'h41);
    `CHK(req, 1'h1)
    src.sync(1'h1, 1'h0);
    `CHK(req, 1'h0)
    src.field(1'h1);
    wr(IC, 32'h9);
    frame();
    `CHK(fodd, 1'h1)
    wr(IC, 32'h89);
    frame();
    `CHK(fodd, 1'h0)
    wr(IC, 32'h81);
    frame();
    `CHK(fodd, 1'h1)
    wr(HM, 32'h410);
    pix(1'h0, 1'h1, 48'h444444, 0, 48'h0);
    pix(1'h1, 1'h1, 48'h555555, 1, 48'h555555);
    wr(SR, 32'h1);
    rdc(HM, 32'h410);
    rdc(IC, 32'h0);
    `CHK(req, 1'h1)
    wr(HM, 32'h90);
    wr(SR, 32'h1);
    rdc(HM, 32'h90);
    src.stream(48'h5A5A5A_A5A5A5);
    repeat (10) @(posedge ref_clk);
    `CHK(ddata, 48'h5A5A5A_A5A5A5)
    `CHK(dctl, first_ctl)
    `CHK(dclk, pclk)
    wr(SR, 32'h1);
    wr(HM, 32'h290);
    wr(IC, 32'h1);
    frame();
    pix(1'h0, 1'h1, 48'h666666, 0, 48'h0);
    `CHK(ddata, 48'h0)
    `CHK(req, 1'h1)
    wr(HM, 32'h10);
    wr(SR, 32'h1);
    rdc(IC, 32'h0);
    wr(IC, 32'h1);
    frame();
    pix(1'h0, 1'h1, 48'h777777, 1, 48'h777777);
    report_and_stop();
  end
endmodule // video_input_port_control_test
